// ### design/pssp_glitch_filter.sv
module pssp_glitch_filter #(
	parameter int STABLE = 3,
	parameter logic RST_VAL = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Raw pin and clean level
	input wire logic d,
	output logic q
);

	localparam int CW = $clog2(STABLE + 1);

	logic [1:0] sync_reg;
	logic [CW-1:0] cnt_reg;
	logic q_reg;

	// A new level must hold for STABLE samples before it is passed on
	wire differs = sync_reg[1] != q_reg;
	wire settled = cnt_reg == CW'(STABLE - 1);

	// Two-flop synchroniser, then the stability counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_reg <= {2{RST_VAL}};
			cnt_reg <= '0;
			q_reg <= RST_VAL;
		end else begin
			sync_reg <= {sync_reg[0], d};
			if (!differs) begin
				cnt_reg <= '0;
			end else if (settled) begin
				q_reg <= sync_reg[1];
				cnt_reg <= '0;
			end else begin
				cnt_reg <= cnt_reg + 1'b1;
			end
		end
	end

	assign q = q_reg;

endmodule // pssp_glitch_filter

// ### design/pssp_slave.sv
`include "pssp_map.svh"

// Summary of operation
// - Nothing on the bus is acted on until a start condition is seen.
// - Stop is data rising while clock high; every operation ends with stop.
// - Any data change while clock is high is taken as start or stop.
// - Upper address nibble must equal the device-type code to proceed.
// - Lower address nibble must equal the four strap pins.
// - Receiver acknowledges each byte by pulling data low on ninth clock.
// - Acknowledge a matching address and every written byte afterwards.
// - Read: send 8 bits, sample master ack, repeat if acked, else wait.
// - Write is start, address, instruction, data, stop; each byte acked.
// - Stop after a stored-register write starts a programming cycle.
// - While programming, ignore the bus and leave data released.
// - Polling address is not acknowledged until programming ends.
// - Write-protect low: ack address and instruction, nack data, no program; data of a wiper write is still acked and passed on.
// - Write-protect falling after programming began does not affect it.
// - Pulses under 50 ns on clock and data are not taken as edges.
// - Instruction is opcode, stored-register select, pot select, MSB first.
module pssp_slave
	import pssp_pkg::*;
#(
	parameter logic [3:0] DEV_TYPE = `PSSP_DEV_TYPE_DEFAULT,
	parameter int NV_PROG_CYCLES = `PSSP_NV_PROG_CYCLES,
	parameter int FILT_CYCLES = `PSSP_FILT_CYCLES
) (
	// System clock domain
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ce,
	// Link oversampling clock
	input wire logic link_clk,
	// Two-wire bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	// Address straps and write protect
	input wire logic addr_strap_bit0,
	input wire logic addr_strap_bit1,
	input wire logic addr_strap_bit2,
	input wire logic addr_strap_bit3,
	input wire logic wp_n,
	// Core side
	output logic cmd_valid,
	output logic rd_req,
	output logic [3:0] cmd_opcode,
	output logic [1:0] cmd_stored_sel,
	output logic [1:0] cmd_pot_sel,
	output logic [7:0] cmd_data,
	input wire logic [7:0] rd_data,
	output logic nv_busy
);

	localparam int PW = $clog2(NV_PROG_CYCLES + 1);
	localparam int NPIN = 8;

	// ------------------------------------------------------------
	// Link domain: reset release and pin conditioning
	// ------------------------------------------------------------
	logic [1:0] lrst_reg;
	wire lrst_n = lrst_reg[1];

	// Reset is released synchronously to the link clock
	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst)
			lrst_reg <= 2'b00;
		else
			lrst_reg <= {lrst_reg[0], 1'b1};
	end

	wire [NPIN-1:0] pin_raw = {ce, wp_n, addr_strap_bit3, addr_strap_bit2,
		addr_strap_bit1, addr_strap_bit0, sda_i, scl_i};
	wire [NPIN-1:0] pin_f;

	// Every outside level is synchronised and deglitched alike
	genvar g;
	generate
		for (g = 0; g < NPIN; g++) begin : g_pin
			pssp_glitch_filter #(
				.STABLE(FILT_CYCLES),
				.RST_VAL(1'b1)
			) u_filt (
				.clk(link_clk),
				.rst_n(lrst_n),
				.d(pin_raw[g]),
				.q(pin_f[g])
			);
		end
	endgenerate

	wire scl_f = pin_f[0];
	wire sda_f = pin_f[1];
	wire [3:0] strap_f = pin_f[5:2];
	wire wp_low = ~pin_f[6];
	wire ce_l = pin_f[7];

	// ------------------------------------------------------------
	// Link domain: declarations
	// ------------------------------------------------------------
	logic scl_q, sda_q;
	logic [1:0] busy_s_reg, rdack_s_reg;
	pssp_link_state_t state_reg, state_next;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg, instr_reg, data_reg, tx_byte_reg;
	logic instr_ok_reg, has_data_reg, mack_reg;
	logic cmd_tgl_reg, cmd_nv_reg, rd_tgl_reg;
	logic sda_o_reg, sda_oe_n_reg, oe_next;
	logic ack_now;

	// Signals coming back from the system domain
	logic busy_reg, rdack_tgl_reg;
	logic [7:0] rd_hold_reg;

	// ------------------------------------------------------------
	// Link domain: bus event decode
	// ------------------------------------------------------------
	wire scl_rise = ce_l & scl_f & ~scl_q;
	wire scl_fall = ce_l & ~scl_f & scl_q;
	wire start_det = ce_l & scl_f & scl_q & sda_q & ~sda_f;
	wire stop_det = ce_l & scl_f & scl_q & ~sda_q & sda_f;
	wire byte_done = scl_fall & (bit_cnt_reg == 4'h8);
	wire ack_done = scl_fall & (bit_cnt_reg == 4'h9);
	wire busy_l = busy_s_reg[1];
	wire rd_ready = rdack_s_reg[1] == rd_tgl_reg;

	// Instruction fields, opcode in the upper nibble
	wire [3:0] op = instr_reg[`PSSP_INSTR_OP_MSB:`PSSP_INSTR_OP_LSB];
	wire [3:0] op_rx = shift_reg[`PSSP_INSTR_OP_MSB:`PSSP_INSTR_OP_LSB];
	wire is_read = (op == `PSSP_OP_RD_WIPER) | (op == `PSSP_OP_RD_STORED);
	wire rx_read = (op_rx == `PSSP_OP_RD_WIPER) |
		(op_rx == `PSSP_OP_RD_STORED);
	wire nv_op = (op == `PSSP_OP_WR_STORED) |
		(op == `PSSP_OP_XFR_TO_STORED) | (op == `PSSP_OP_GANG_TO_STORED);
	wire needs_data = (op == `PSSP_OP_WR_STORED) |
		(op == `PSSP_OP_WR_WIPER);

	// Both nibbles must match; busy hides the device from polling
	wire type_ok =
		shift_reg[`PSSP_ADDR_TYPE_MSB:`PSSP_ADDR_TYPE_LSB] == DEV_TYPE;
	wire strap_ok =
		shift_reg[`PSSP_ADDR_STRAP_MSB:`PSSP_ADDR_STRAP_LSB] == strap_f;
	wire addr_match = type_ok & strap_ok & ~busy_l;

	// A protected stored write never reaches the core
	wire cmd_fire = instr_ok_reg & ~is_read & ~(nv_op & wp_low) &
		(~needs_data | has_data_reg);

	// Byte to send: fresh core answer at the start of a read
	wire [7:0] tx_first = (state_reg != LK_INSTR) ? tx_byte_reg :
		(rd_ready ? rd_hold_reg : `PSSP_TX_IDLE);
	wire [2:0] tx_idx = 3'd7 - bit_cnt_reg[2:0];

	// ------------------------------------------------------------
	// Link domain: acknowledge and state decisions
	// ------------------------------------------------------------
	always_comb begin
		case (state_reg)
			LK_ADDR: ack_now = addr_match;
			LK_INSTR: ack_now = 1'b1;
			LK_DATA: ack_now = ~(nv_op & wp_low);
			default: ack_now = 1'b0;
		endcase
	end

	always_comb begin
		state_next = state_reg;
		if (start_det) begin
			state_next = LK_ADDR;
		end else if (stop_det) begin
			state_next = LK_IDLE;
		end else if (byte_done && !ack_now && state_reg != LK_TX) begin
			state_next = LK_IDLE;
		end else if (ack_done) begin
			case (state_reg)
				LK_ADDR: state_next = LK_INSTR;
				LK_INSTR: state_next = is_read ? LK_TX : LK_DATA;
				LK_DATA: state_next = LK_DATA;
				LK_TX: state_next = mack_reg ? LK_TX : LK_IDLE;
				default: state_next = LK_IDLE;
			endcase
		end
	end

	// Data line drive; low enable means the pin is pulled low
	always_comb begin
		oe_next = sda_oe_n_reg;
		if (start_det || stop_det)
			oe_next = 1'b1;
		else if (byte_done)
			oe_next = (state_reg == LK_TX) ? 1'b1 : ~ack_now;
		else if (ack_done)
			oe_next = (state_next == LK_TX) ? tx_first[7] : 1'b1;
		else if (scl_fall && state_reg == LK_TX && bit_cnt_reg != 4'h0)
			oe_next = tx_byte_reg[tx_idx];
	end

	// ------------------------------------------------------------
	// Link domain: registers
	// ------------------------------------------------------------
	// Previous levels and return-path synchronisers
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			busy_s_reg <= 2'b00;
			rdack_s_reg <= 2'b00;
		end else begin
			busy_s_reg <= {busy_s_reg[0], busy_reg};
			rdack_s_reg <= {rdack_s_reg[0], rdack_tgl_reg};
			if (ce_l) begin
				scl_q <= scl_f;
				sda_q <= sda_f;
			end
		end
	end

	// Transaction state, bit counter and shifter
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			state_reg <= LK_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			mack_reg <= 1'b0;
			sda_o_reg <= 1'b0;
			sda_oe_n_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			sda_oe_n_reg <= oe_next;
			if (start_det || stop_det || ack_done || state_reg == LK_IDLE)
				bit_cnt_reg <= 4'h0;
			else if (scl_rise)
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			if (scl_rise && bit_cnt_reg < 4'h8)
				shift_reg <= {shift_reg[6:0], sda_f};
			if (scl_rise && bit_cnt_reg == 4'h8 && state_reg == LK_TX)
				mack_reg <= ~sda_f;
		end
	end

	// Captured bytes and requests toward the system domain
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			instr_reg <= 8'h00;
			data_reg <= 8'h00;
			tx_byte_reg <= 8'h00;
			instr_ok_reg <= 1'b0;
			has_data_reg <= 1'b0;
			cmd_tgl_reg <= 1'b0;
			cmd_nv_reg <= 1'b0;
			rd_tgl_reg <= 1'b0;
		end else begin
			if (start_det) begin
				instr_ok_reg <= 1'b0;
				has_data_reg <= 1'b0;
			end else if (stop_det) begin
				instr_ok_reg <= 1'b0;
				if (cmd_fire) begin
					cmd_tgl_reg <= ~cmd_tgl_reg;
					cmd_nv_reg <= nv_op;
				end
			end else if (byte_done && state_reg == LK_INSTR) begin
				instr_reg <= shift_reg;
				instr_ok_reg <= 1'b1;
				if (rx_read)
					rd_tgl_reg <= ~rd_tgl_reg;
			end else if (byte_done && state_reg == LK_DATA && ack_now) begin
				data_reg <= shift_reg;
				has_data_reg <= 1'b1;
			end
			if (ack_done)
				tx_byte_reg <= tx_first;
		end
	end

	assign sda_o = sda_o_reg;
	assign sda_oe_n = sda_oe_n_reg;

	// ------------------------------------------------------------
	// System domain
	// ------------------------------------------------------------
	logic [2:0] cmd_s_reg, rd_s_reg;
	logic [PW-1:0] prog_cnt_reg;
	logic cmd_valid_reg, rd_req_reg, rd_wait_reg;
	logic [7:0] instr_out_reg, data_out_reg;

	// Toggles become one-cycle events past two synchronising flops
	wire cmd_evt = cmd_s_reg[2] ^ cmd_s_reg[1];
	wire rd_evt = rd_s_reg[2] ^ rd_s_reg[1];
	wire prog_done = prog_cnt_reg == '0;

	// Event capture; link bytes are stable while their toggle settles
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cmd_s_reg <= 3'b000;
			rd_s_reg <= 3'b000;
			cmd_valid_reg <= 1'b0;
			rd_req_reg <= 1'b0;
			rd_wait_reg <= 1'b0;
			instr_out_reg <= 8'h00;
			data_out_reg <= 8'h00;
			rd_hold_reg <= 8'h00;
			rdack_tgl_reg <= 1'b0;
		end else if (ce) begin
			cmd_s_reg <= {cmd_s_reg[1:0], cmd_tgl_reg};
			rd_s_reg <= {rd_s_reg[1:0], rd_tgl_reg};
			cmd_valid_reg <= cmd_evt;
			rd_req_reg <= rd_evt;
			rd_wait_reg <= rd_evt;
			if (cmd_evt || rd_evt)
				instr_out_reg <= instr_reg;
			if (cmd_evt)
				data_out_reg <= data_reg;
			if (rd_wait_reg) begin
				rd_hold_reg <= rd_data;
				rdack_tgl_reg <= ~rdack_tgl_reg;
			end
		end
	end

	// Programming timer; write protect is not looked at once it runs
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			busy_reg <= 1'b0;
			prog_cnt_reg <= '0;
		end else if (ce) begin
			if (cmd_evt && cmd_nv_reg) begin
				busy_reg <= 1'b1;
				prog_cnt_reg <= PW'(NV_PROG_CYCLES - 1);
			end else if (busy_reg) begin
				if (prog_done)
					busy_reg <= 1'b0;
				else
					prog_cnt_reg <= prog_cnt_reg - 1'b1;
			end
		end
	end

	assign cmd_valid = cmd_valid_reg;
	assign rd_req = rd_req_reg;
	assign cmd_opcode =
		instr_out_reg[`PSSP_INSTR_OP_MSB:`PSSP_INSTR_OP_LSB];
	assign cmd_stored_sel =
		instr_out_reg[`PSSP_INSTR_STORED_MSB:`PSSP_INSTR_STORED_LSB];
	assign cmd_pot_sel =
		instr_out_reg[`PSSP_INSTR_POT_MSB:`PSSP_INSTR_POT_LSB];
	assign cmd_data = data_out_reg;
	assign nv_busy = busy_reg;

endmodule // pssp_slave

// ### include/pssp_map.svh
`ifndef PSSP_MAP_SVH
`define PSSP_MAP_SVH

// ----------------------------------------------------------------
// Address byte layout
// ----------------------------------------------------------------
// Device-type nibble default; the value is arbitrary
`define PSSP_DEV_TYPE_DEFAULT 4'ha
`define PSSP_ADDR_TYPE_MSB 7
`define PSSP_ADDR_TYPE_LSB 4
`define PSSP_ADDR_STRAP_MSB 3
`define PSSP_ADDR_STRAP_LSB 0

// ----------------------------------------------------------------
// Instruction byte layout
// ----------------------------------------------------------------
`define PSSP_INSTR_OP_MSB 7
`define PSSP_INSTR_OP_LSB 4
`define PSSP_INSTR_STORED_MSB 3
`define PSSP_INSTR_STORED_LSB 2
`define PSSP_INSTR_POT_MSB 1
`define PSSP_INSTR_POT_LSB 0

// ----------------------------------------------------------------
// Opcodes the port must classify
// ----------------------------------------------------------------
`define PSSP_OP_RD_WIPER 4'h9
`define PSSP_OP_WR_WIPER 4'ha
`define PSSP_OP_RD_STORED 4'hb
`define PSSP_OP_WR_STORED 4'hc
`define PSSP_OP_XFR_TO_STORED 4'he
`define PSSP_OP_GANG_TO_STORED 4'h8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PSSP_SYS_CLK_KHZ 40000
`define PSSP_NV_PROGRAM_TIME_MS 5
`define PSSP_NV_PROG_CYCLES (`PSSP_NV_PROGRAM_TIME_MS * `PSSP_SYS_CLK_KHZ)
`define PSSP_LINK_CLK_NS 30
`define PSSP_GLITCH_NS 50
`define PSSP_FILT_CYCLES \
	((`PSSP_GLITCH_NS + `PSSP_LINK_CLK_NS - 1) / `PSSP_LINK_CLK_NS + 1)
// Idle byte sent when the core has not answered a read in time
`define PSSP_TX_IDLE 8'hff

`endif

// ### include/pssp_pkg.sv
package pssp_pkg;

	// Position of the bus transaction at the link
	typedef enum logic [2:0] {
		LK_IDLE,
		LK_ADDR,
		LK_INSTR,
		LK_DATA,
		LK_TX
	} pssp_link_state_t;

endpackage

// ### verification/pssp_bus_master.sv
module pssp_bus_master #(
	parameter int T = 400
) (
	// Lines driven by the master
	output logic scl,
	output logic sda_drv,
	// Wire level
	input wire logic sda_in
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle bus: both released high; only this side makes the clock
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	// Data falls with the clock high, from an idle bus
	task automatic start();
		sda_drv = 1'b1;
		#T scl = 1'b1;
		#T sda_drv = 1'b0;
		#T scl = 1'b0;
		#T;
	endtask

	// Data rises with the clock high; long gap keeps the bus free after
	task automatic stop();
		sda_drv = 1'b0;
		#T scl = 1'b1;
		#T sda_drv = 1'b1;
		#(4 * T);
	endtask

	// Data moves only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		sda_drv = b;
		#T scl = 1'b1;
		#T r = sda_in;
		#T scl = 1'b0;
		#T;
	endtask

	// Byte MSB first, then the ninth clock for the acknowledge
	task automatic xfer(input logic [7:0] d, input logic last,
		output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(last, ack);
	endtask

	// Clock spike of 20 ns, then the clock parks low
	task automatic glitch();
		scl = 1'b1;
		#20 scl = 1'b0;
		#T;
	endtask
endmodule // pssp_bus_master

// ### verification/pssp_monitor.sv
`include "pssp_map.svh"

module pssp_monitor #(
	parameter int NV_PROG_CYCLES = `PSSP_NV_PROG_CYCLES
) (
	// Clocks and reset
	input wire logic sys_clk,
	input wire logic link_clk,
	input wire logic nrst,
	// Bus side
	input wire logic scl_i,
	input wire logic sda_oe_n,
	input wire logic wp_n,
	// Core side
	input wire logic cmd_valid,
	input wire logic rd_req,
	input wire logic [3:0] cmd_opcode,
	input wire logic [7:0] cmd_data,
	input wire logic nv_busy
);
	timeunit 1ns;
	timeprecision 100ps;

	int busy_cnt;

	// Length of the current programming cycle, in sys_clk cycles
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			busy_cnt <= 0;
		else if (nv_busy)
			busy_cnt <= busy_cnt + 1;
		else
			busy_cnt <= 0;
	end

	// ----------------
	// Core side
	// ----------------
	property p_cmd1;
		@(posedge sys_clk) disable iff (!nrst) cmd_valid |=> !cmd_valid;
	endproperty
	a_cmd1: assert property (p_cmd1) else $error("cmd pulse");
	property p_op;
		@(posedge sys_clk) disable iff (!nrst)
		$changed(cmd_opcode) |-> cmd_valid || rd_req;
	endproperty
	a_op: assert property (p_op) else $error("opcode moved");
	property p_brise;
		@(posedge sys_clk) disable iff (!nrst) $rose(nv_busy) |-> cmd_valid;
	endproperty
	a_brise: assert property (p_brise) else $error("busy cause");
	// Counter read at the fall; a wrong cycle length shows here, a busy stuck low or high never falls and does not
	property p_blen;
		@(posedge sys_clk) disable iff (!nrst)
		$fell(nv_busy) |-> busy_cnt == NV_PROG_CYCLES;
	endproperty
	a_blen: assert property (p_blen) else $error("busy length");
	property p_bhold;
		@(posedge sys_clk) disable iff (!nrst)
		nv_busy && !wp_n && busy_cnt < NV_PROG_CYCLES - 1 |=> nv_busy;
	endproperty
	a_bhold: assert property (p_bhold) else $error("busy cut");
	property p_stored;
		@(posedge sys_clk) disable iff (!nrst)
		cmd_valid && cmd_opcode == `PSSP_OP_WR_STORED |-> nv_busy;
	endproperty
	a_stored: assert property (p_stored) else $error("no prog");
	property p_wiper;
		@(posedge sys_clk) disable iff (!nrst)
		cmd_valid && cmd_opcode == `PSSP_OP_WR_WIPER |-> !nv_busy;
	endproperty
	a_wiper: assert property (p_wiper) else $error("wiper prog");
	property p_quiet;
		@(posedge sys_clk) disable iff (!nrst) nv_busy |-> sda_oe_n;
	endproperty
	a_quiet: assert property (p_quiet) else $error("busy drive");

	// ----------------
	// Bus side
	// ----------------
	// The device may only move the data line while the clock is low
	property p_edge;
		@(posedge link_clk) disable iff (!nrst)
		$changed(sda_oe_n) |-> !scl_i;
	endproperty
	a_edge: assert property (p_edge) else $error("sda at scl high");

	c_prog: cover property (@(posedge sys_clk) $fell(nv_busy));
	c_read: cover property (@(posedge sys_clk) rd_req);
	c_cmd: cover property (@(posedge sys_clk) cmd_valid && !nv_busy);
endmodule // pssp_monitor

// ### verification/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int NVP = 2000;
	localparam logic [3:0] DTY = 4'h6; // arbitrary type code
	localparam logic [3:0] STRAP = 4'h9;
	localparam logic [7:0] ADR = {DTY, STRAP};
	typedef struct {
		logic [7:0] adr, ins, dat;
		logic wp;
		logic [2:0] ack;
		logic cmd, busy;
	} pssp_row_t;

	logic sys_clk, link_clk, nrst, ce, wp_n, scl, m_sda, sda_o, sda_oe_n;
	logic cmd_valid, rd_req, nv_busy;
	logic [3:0] cmd_opcode;
	logic [1:0] cmd_stored_sel, cmd_pot_sel;
	logic [7:0] cmd_data, rd_data, cap_ins, cap_dat, q;
	int err_count = 0, checks_done = 0, n_cmd = 0, n_rd = 0;
	pssp_row_t rows[7];
	// Open drain: either party pulls low, otherwise the pull-up wins
	wire sda_w = m_sda & (sda_oe_n | sda_o);

	// Two clocks of unrelated phase
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial begin
		link_clk = 1'b0;
		#7;
		forever #15 link_clk = ~link_clk;
	end

	pssp_slave #(.DEV_TYPE(DTY), .NV_PROG_CYCLES(NVP)) uut (
		.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .link_clk(link_clk),
		.scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
		.addr_strap_bit0(STRAP[0]), .addr_strap_bit1(STRAP[1]),
		.addr_strap_bit2(STRAP[2]), .addr_strap_bit3(STRAP[3]),
		.wp_n(wp_n), .cmd_valid(cmd_valid), .rd_req(rd_req),
		.cmd_opcode(cmd_opcode), .cmd_stored_sel(cmd_stored_sel),
		.cmd_pot_sel(cmd_pot_sel), .cmd_data(cmd_data),
		.rd_data(rd_data), .nv_busy(nv_busy)
	);
	pssp_bus_master m (.scl(scl), .sda_drv(m_sda), .sda_in(sda_w));

	// Core-side events and the fields they carried
	always @(posedge sys_clk) begin
		if (cmd_valid === 1'b1) begin
			n_cmd <= n_cmd + 1;
			cap_dat <= cmd_data;
		end
		if (rd_req === 1'b1)
			n_rd <= n_rd + 1;
		if (cmd_valid === 1'b1 || rd_req === 1'b1)
			cap_ins <= {cmd_opcode, cmd_stored_sel, cmd_pot_sel};
	end

	// ----------------
	// Helpers
	// ----------------
	task automatic sy(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Address-only probe, the way a host polls for the end of programming
	task automatic poll(input logic exp);
		logic a;
		m.start();
		m.xfer(ADR, 1'b1, q, a);
		m.stop();
		check(8'(a), 8'(exp));
	endtask
	// Protect drops and a poll arrives while programming runs; a second poll follows its end
	task automatic prog_wait();
		int t;
		wp_n = 1'b0;
		poll(1'b1);
		check(8'(nv_busy), 8'h01);
		for (t = 0; t < NVP + 40 && nv_busy !== 1'b0; t++)
			sy(1);
		if (t == NVP + 40) begin
			err_count++;
			end_of_test();
		end
		poll(1'b0);
		wp_n = 1'b1;
	endtask

	// ----------------
	// Main sequence
	// ----------------
	initial begin
		pssp_row_t r;
		logic [2:0] a;
		int nc, t;
		nrst = 1'b0;
		ce = 1'b1;
		wp_n = 1'b1;
		rd_data = 8'hb6;
		rows = '{
			'{ADR, 8'ha2, 8'h3c, 1'b1, 3'b000, 1'b1, 1'b0},
			'{ADR, 8'hc7, 8'h15, 1'b1, 3'b000, 1'b1, 1'b1},
			'{ADR, 8'hc2, 8'h2a, 1'b0, 3'b001, 1'b0, 1'b0},
			'{{~DTY, STRAP}, 8'ha1, 8'h11, 1'b1, 3'b111, 1'b0, 1'b0},
			'{{DTY, ~STRAP}, 8'ha1, 8'h11, 1'b1, 3'b111, 1'b0, 1'b0},
			'{ADR, 8'he5, 8'h5a, 1'b1, 3'b000, 1'b1, 1'b1},
			'{ADR, 8'h84, 8'h33, 1'b0, 3'b001, 1'b0, 1'b0}
		};
		sy(10);
		check(8'(sda_oe_n), 8'h01);
		check({4'h0, sda_o, cmd_valid, rd_req, nv_busy}, 8'h00);
		nrst = 1'b1;
		sy(20);
		// No start, then a start with a clock spike before the address byte
		for (int g = 0; g < 2; g++) begin
			if (g == 1)
				m.start();
			m.glitch();
			m.xfer(ADR, 1'b1, q, a[0]);
			m.stop();
			check(8'(a[0]), 8'(g == 0));
		end
		foreach (rows[k]) begin
			r = rows[k];
			sy(1);
			wp_n = r.wp;
			nc = n_cmd;
			m.start();
			m.xfer(r.adr, 1'b1, q, a[2]);
			m.xfer(r.ins, 1'b1, q, a[1]);
			m.xfer(r.dat, 1'b1, q, a[0]);
			m.stop();
			check(8'(a), 8'(r.ack));
			for (t = 0; t < 40 && n_cmd == nc; t++)
				sy(1);
			check(8'(n_cmd - nc), 8'(r.cmd));
			if (r.cmd)
				check(cap_ins, r.ins);
			if (r.cmd)
				check(cap_dat, r.dat);
			check(8'(nv_busy), 8'(r.busy));
			if (r.busy)
				prog_wait();
		end
		// Read repeats the byte while acked and stops after a nack
		nc = n_rd;
		m.start();
		m.xfer(ADR, 1'b1, q, a[2]);
		m.xfer(8'h93, 1'b1, q, a[1]);
		m.xfer(8'hff, 1'b0, q, a[0]);
		check(q, 8'hb6);
		m.xfer(8'hff, 1'b1, q, a[0]);
		check(q, 8'hb6);
		m.stop();
		check(8'(a[2:1]), 8'h00);
		check(8'(n_rd - nc), 8'h01);
		check(cap_ins, 8'h93);
		end_of_test();
	end
endmodule // tb

bind pssp_slave pssp_monitor #(.NV_PROG_CYCLES(NV_PROG_CYCLES)) u_mon (
	.sys_clk(sys_clk), .link_clk(link_clk), .nrst(nrst), .scl_i(scl_i),
	.sda_oe_n(sda_oe_n), .wp_n(wp_n), .cmd_valid(cmd_valid),
	.rd_req(rd_req), .cmd_opcode(cmd_opcode), .cmd_data(cmd_data),
	.nv_busy(nv_busy)
);
